// [hw/pfsw_cfg.svh]
// Summary of operation
// R1: Row holds 32 words, 96 bytes
// R2: Panel holds 128 rows, 4K words
// R3: Erase one row; program 32 words
// R4: Panel latches buffer 32 words before program
// R5: Software loads latches in ascending order
// R6: Latch addresses start on row boundary
// R7: Low table access covers bits 15 to 0
// R8: High table access covers bits 23 to 16
// R9: Address is page byte plus effective address
// R10: Software issues 32 low, 32 high writes
// R11: Table write completes in two cycles
// R12: Low address captures last effective address
// R13: Upper address captures last page byte
// R14: Address registers are directly writable
// R15: Key register is write-only protection
// R16: Keys 55 then AA permit start
// R17: Start bit 15 launches the operation
// R18: Hardware clears start bit when finished
// R19: Operation lasts 2 ms, processor stalls
// R20: Control selects operation and holds start
// R21: Software sets operation and write enable first
// R22: Software follows start with two idle cycles
// R23: Intervening write or wrong key blocks start
`ifndef PFSW_CFG_SVH
`define PFSW_CFG_SVH
// ****************************************
// Geometry
// ****************************************
`define PFSW_ROW_WORDS 32
`define PFSW_PANEL_ROWS 128
`define PFSW_PANEL_WORDS 4096
`define PFSW_ERASED 24'hFFFFFF
// ****************************************
// Register offsets
// ****************************************
`define PFSW_ADDR_CTRL 16'h0760
`define PFSW_ADDR_LOW 16'h0762
`define PFSW_ADDR_UPPER 16'h0764
`define PFSW_ADDR_KEY 16'h0766
// ****************************************
// Control fields and values
// ****************************************
`define PFSW_BIT_WR 15
`define PFSW_BIT_WEN 14
`define PFSW_BIT_WRERR 13
`define PFSW_BIT_TWRI 8
`define PFSW_CTRL_RESET 16'h0000
`define PFSW_OP_ERASE_ROW 7'h41
`define PFSW_OP_PROG_ROW 7'h01
`define PFSW_CTRL_ERASE 16'h4041
`define PFSW_CTRL_PROG 16'h4001
`define PFSW_CTRL_START 16'h8000
`define PFSW_KEY_FIRST 8'h55
`define PFSW_KEY_SECOND 8'hAA
// ****************************************
// Timing
// ****************************************
`define PFSW_OP_TIME_US 2000
`define PFSW_CLK_MHZ 10
`define PFSW_NOP_CYCLES 2'h2
`endif

// [hw/pfsw_dev.sv]
`default_nettype none
`include "pfsw_cfg.svh"
module pfsw_dev
  import pfsw_pkg::*;
#(
  parameter int unsigned OP_CYCLES = `PFSW_OP_TIME_US * `PFSW_CLK_MHZ
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  pfsw_if.dev BUS,
  output logic BUSY_O,
  output logic OP_DONE_O
);
  // ****************************************
  // Storage and state
  // ****************************************
  pfsw_word_t flash_mem [0:`PFSW_PANEL_WORDS-1];
  pfsw_word_t write_latch [0:`PFSW_ROW_WORDS-1];
  pfsw_dev_state_t state;
  pfsw_key_state_t key_state;
  logic [15:0] address_low;
  logic [7:0] address_upper;
  logic wr, wen, wrerr, twri;
  logic [6:0] progop;
  logic [31:0] op_count;
  logic tbl_pend, reg_rvalid;
  logic [15:0] tbl_rdata, reg_rdata;
  logic [23:0] tbl_addr, nvm_addr;
  logic idle, take_tbl, wr_ctrl, start_req, op_valid, start, bad_op, done;
  pfsw_word_t rd_word;

  // ****************************************
  // Address helpers
  // ****************************************
  // Word index within the panel, two address units per instruction word
  function automatic logic [11:0] word_index(input logic [23:0] a);
    return a[12:1]; // R2
  endfunction

  // Position of a word inside its row
  function automatic logic [4:0] latch_index(input logic [23:0] a);
    return a[5:1]; // R1
  endfunction

  // First word index of the row holding an address
  function automatic logic [11:0] row_base(input logic [23:0] a);
    return {a[12:6], 5'h00}; // R1
  endfunction

  // ****************************************
  // Request decode
  // ****************************************
  // Program address built from page byte and effective address
  assign tbl_addr = {BUS.tbl_page, BUS.tbl_ofs}; // R9
  assign nvm_addr = {address_upper, address_low};
  assign idle = (state == PFSW_D_IDLE);
  assign take_tbl = BUS.tbl_req && !tbl_pend && idle;
  assign wr_ctrl = BUS.reg_wr && idle && (BUS.reg_addr == `PFSW_ADDR_CTRL);
  // Start only straight after the two keys, with writes enabled
  assign start_req = wr_ctrl && BUS.reg_wdata[`PFSW_BIT_WR] && BUS.reg_wdata[`PFSW_BIT_WEN]
                     && (key_state == PFSW_K_ARMED); // R16
  assign op_valid = (BUS.reg_wdata[6:0] == `PFSW_OP_ERASE_ROW)
                    || (BUS.reg_wdata[6:0] == `PFSW_OP_PROG_ROW); // R20
  assign start = start_req && op_valid; // R17
  assign bad_op = start_req && !op_valid;
  assign done = !idle && (op_count == OP_CYCLES - 1); // R19
  assign rd_word = flash_mem[word_index(tbl_addr)];

  // Processor stall while an erase or program runs
  assign BUS.stall = !idle; // R19
  assign BUSY_O = !idle;
  assign BUS.tbl_ack = tbl_pend; // R11
  assign BUS.tbl_rdata = tbl_rdata;
  assign BUS.reg_rdata = reg_rdata;
  assign BUS.reg_rvalid = reg_rvalid;

  // ****************************************
  // Operation sequencer
  // ****************************************
  // Idle, erase or program
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state <= PFSW_D_IDLE;
    end else begin
      unique case (state)
        PFSW_D_IDLE: begin
          if (start) begin
            state <= (BUS.reg_wdata[6:0] == `PFSW_OP_ERASE_ROW) ? PFSW_D_ERASE : PFSW_D_PROG;
          end
        end
        PFSW_D_ERASE, PFSW_D_PROG: begin
          if (done) begin
            state <= PFSW_D_IDLE;
          end
        end
        default: begin
          state <= PFSW_D_IDLE;
        end
      endcase
    end
  end

  // Duration counter for the running operation
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      op_count <= 32'h00000000;
    end else if (idle || done) begin
      op_count <= 32'h00000000;
    end else begin
      op_count <= op_count + 32'h00000001; // R19
    end
  end

  // Completion pulse
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      OP_DONE_O <= 1'b0;
    end else begin
      OP_DONE_O <= done;
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  // Start bit set by an unlocked write, cleared by hardware at the end
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wr <= 1'(`PFSW_CTRL_RESET >> `PFSW_BIT_WR);
    end else if (done) begin
      wr <= 1'b0; // R18
    end else if (start) begin
      wr <= 1'b1; // R17
    end
  end

  // Operation select and write enable fields
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wen <= 1'b0;
      twri <= 1'b0;
      progop <= 7'(`PFSW_CTRL_RESET);
    end else if (wr_ctrl) begin
      wen <= BUS.reg_wdata[`PFSW_BIT_WEN];
      twri <= BUS.reg_wdata[`PFSW_BIT_TWRI];
      progop <= BUS.reg_wdata[6:0]; // R20
    end
  end

  // Error flag on a start with an unknown operation; set beats clear
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wrerr <= 1'b0;
    end else if (bad_op) begin
      wrerr <= 1'b1;
    end else if (wr_ctrl) begin
      wrerr <= BUS.reg_wdata[`PFSW_BIT_WRERR];
    end
  end

  // ****************************************
  // Unlock key
  // ****************************************
  // Every register write advances or breaks the key sequence
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      key_state <= PFSW_K_NONE;
    end else if (BUS.reg_wr) begin
      if (BUS.reg_addr == `PFSW_ADDR_KEY && BUS.reg_wdata[7:0] == `PFSW_KEY_FIRST) begin
        key_state <= PFSW_K_FIRST; // R16
      end else if (key_state == PFSW_K_FIRST && BUS.reg_addr == `PFSW_ADDR_KEY
                   && BUS.reg_wdata[7:0] == `PFSW_KEY_SECOND) begin
        key_state <= PFSW_K_ARMED; // R16
      end else begin
        key_state <= PFSW_K_NONE; // R23
      end
    end
  end

  // ****************************************
  // Address registers
  // ****************************************
  // Table accesses capture the address; direct writes also load it
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      address_low <= 16'h0000;
      address_upper <= 8'h00;
    end else if (take_tbl) begin
      address_low <= BUS.tbl_ofs; // R12
      address_upper <= BUS.tbl_page; // R13
    end else if (BUS.reg_wr && idle) begin
      if (BUS.reg_addr == `PFSW_ADDR_LOW) begin
        address_low <= BUS.reg_wdata; // R14
      end
      if (BUS.reg_addr == `PFSW_ADDR_UPPER) begin
        address_upper <= BUS.reg_wdata[7:0]; // R14
      end
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  // Read data one cycle after the strobe; key reads as zero
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= BUS.reg_rd;
      if (BUS.reg_rd) begin
        unique case (BUS.reg_addr)
          `PFSW_ADDR_CTRL: reg_rdata <= {wr, wen, wrerr, 4'h0, twri, 1'b0, progop};
          `PFSW_ADDR_LOW: reg_rdata <= address_low;
          `PFSW_ADDR_UPPER: reg_rdata <= {8'h00, address_upper};
          default: reg_rdata <= 16'h0000; // R15
        endcase
      end
    end
  end

  // ****************************************
  // Table accesses
  // ****************************************
  // Two-cycle table access: take, then acknowledge with data
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      tbl_pend <= 1'b0;
      tbl_rdata <= 16'h0000;
    end else begin
      tbl_pend <= take_tbl; // R11
      if (take_tbl && !BUS.tbl_we) begin
        if (!BUS.tbl_high) begin
          tbl_rdata <= !BUS.tbl_byte ? rd_word[15:0] :
                       {8'h00, BUS.tbl_ofs[0] ? rd_word[15:8] : rd_word[7:0]}; // R7
        end else begin
          tbl_rdata <= (BUS.tbl_byte && BUS.tbl_ofs[0]) ? 16'h0000 :
                       {8'h00, rd_word[23:16]}; // R8
        end
      end
    end
  end

  // Write latches take table writes at their position in the row
  always_ff @(posedge CLK_SYS_I) begin
    if (take_tbl && BUS.tbl_we) begin
      if (!BUS.tbl_high) begin
        if (!BUS.tbl_byte) begin
          write_latch[latch_index(tbl_addr)][15:0] <= BUS.tbl_wdata; // R7
        end else if (BUS.tbl_ofs[0]) begin
          write_latch[latch_index(tbl_addr)][15:8] <= BUS.tbl_wdata[7:0]; // R7
        end else begin
          write_latch[latch_index(tbl_addr)][7:0] <= BUS.tbl_wdata[7:0]; // R7
        end
      end else if (!(BUS.tbl_byte && BUS.tbl_ofs[0])) begin
        write_latch[latch_index(tbl_addr)][23:16] <= BUS.tbl_wdata[7:0]; // R8
      end
    end
  end

  // Array update at the end of the operation, one whole row
  always_ff @(posedge CLK_SYS_I) begin
    if (done) begin
      for (int i = 0; i < `PFSW_ROW_WORDS; i++) begin
        if (state == PFSW_D_ERASE) begin
          flash_mem[row_base(nvm_addr) + i[11:0]] <= `PFSW_ERASED; // R3
        end else begin
          flash_mem[row_base(nvm_addr) + i[11:0]] <= write_latch[i]; // R4
        end
      end
    end
  end
endmodule
`default_nettype wire

// [hw/pfsw_host.sv]
`default_nettype none
`include "pfsw_cfg.svh"
module pfsw_host
  import pfsw_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  pfsw_if.host BUS,
  input wire logic CMD_VALID_I,
  input wire logic CMD_PROG_I,
  input wire logic [23:0] CMD_ADDR_I,
  output logic CMD_READY_O,
  output logic [4:0] WORD_IDX_O,
  input wire logic [23:0] WORD_DATA_I,
  input wire logic RD_VALID_I,
  input wire logic [23:0] RD_ADDR_I,
  output logic [23:0] RD_DATA_O,
  output logic RD_DONE_O,
  output logic DONE_O
);
  // ****************************************
  // State
  // ****************************************
  pfsw_host_state_t state;
  logic prog;
  logic [23:0] addr;
  logic [4:0] idx;
  logic [1:0] nop_cnt;
  logic waiting;
  logic [7:0] hi_hold;
  logic [15:0] lo_hold;
  logic tbl_state;
  logic [15:0] ctrl_val;

  assign CMD_READY_O = (state == PFSW_H_IDLE);
  assign WORD_IDX_O = idx;
  assign ctrl_val = prog ? `PFSW_CTRL_PROG : `PFSW_CTRL_ERASE; // R21
  assign tbl_state = (state == PFSW_H_LATLO) || (state == PFSW_H_LATHI)
                     || (state == PFSW_H_RDLO) || (state == PFSW_H_RDHI);

  // ****************************************
  // Bus drive
  // ****************************************
  // Table requests, one at a time, word mode
  assign BUS.tbl_req = tbl_state && !waiting;
  assign BUS.tbl_we = (state == PFSW_H_LATLO) || (state == PFSW_H_LATHI);
  assign BUS.tbl_high = (state == PFSW_H_LATHI) || (state == PFSW_H_RDHI);
  assign BUS.tbl_byte = 1'b0;
  assign BUS.tbl_page = addr[23:16];
  // Latch addresses walk up from the row boundary
  assign BUS.tbl_ofs = BUS.tbl_we ? {addr[15:6], idx, 1'b0} : addr[15:0]; // R5 R6
  assign BUS.tbl_wdata = (state == PFSW_H_LATHI) ? {8'h00, hi_hold} : WORD_DATA_I[15:0];
  assign BUS.reg_rd = 1'b0;

  // Register writes: control, address, keys, start
  always_comb begin
    BUS.reg_wr = 1'b1;
    BUS.reg_addr = `PFSW_ADDR_CTRL;
    BUS.reg_wdata = ctrl_val;
    unique case (state)
      PFSW_H_CTRL: BUS.reg_wdata = ctrl_val; // R21
      PFSW_H_ADRU: begin
        BUS.reg_addr = `PFSW_ADDR_UPPER;
        BUS.reg_wdata = {8'h00, addr[23:16]};
      end
      PFSW_H_ADRL: begin
        BUS.reg_addr = `PFSW_ADDR_LOW;
        BUS.reg_wdata = {addr[15:6], 6'h00};
      end
      PFSW_H_KEY1: begin
        BUS.reg_addr = `PFSW_ADDR_KEY;
        BUS.reg_wdata = {8'h00, `PFSW_KEY_FIRST}; // R16
      end
      PFSW_H_KEY2: begin
        BUS.reg_addr = `PFSW_ADDR_KEY;
        BUS.reg_wdata = {8'h00, `PFSW_KEY_SECOND}; // R16
      end
      PFSW_H_START: BUS.reg_wdata = ctrl_val | `PFSW_CTRL_START; // R17
      default: BUS.reg_wr = 1'b0;
    endcase
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // Erase: control, address, keys, start; program: control, latches, keys, start
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state <= PFSW_H_IDLE;
    end else begin
      unique case (state)
        PFSW_H_IDLE: begin
          if (CMD_VALID_I) begin
            state <= PFSW_H_CTRL;
          end else if (RD_VALID_I) begin
            state <= PFSW_H_RDLO;
          end
        end
        PFSW_H_CTRL: state <= prog ? PFSW_H_LATLO : PFSW_H_ADRU;
        PFSW_H_ADRU: state <= PFSW_H_ADRL;
        PFSW_H_ADRL: state <= PFSW_H_KEY1;
        PFSW_H_LATLO: begin
          if (BUS.tbl_ack) begin
            state <= PFSW_H_LATHI;
          end
        end
        PFSW_H_LATHI: begin
          if (BUS.tbl_ack) begin
            state <= (idx == 5'h1F) ? PFSW_H_KEY1 : PFSW_H_LATLO; // R10
          end
        end
        PFSW_H_KEY1: state <= PFSW_H_KEY2;
        PFSW_H_KEY2: state <= PFSW_H_START;
        PFSW_H_START: state <= PFSW_H_NOP;
        PFSW_H_NOP: begin
          if (nop_cnt == `PFSW_NOP_CYCLES - 2'h1) begin
            state <= PFSW_H_WAIT; // R22
          end
        end
        PFSW_H_WAIT: begin
          if (!BUS.stall) begin
            state <= PFSW_H_IDLE;
          end
        end
        PFSW_H_RDLO: begin
          if (BUS.tbl_ack) begin
            state <= PFSW_H_RDHI;
          end
        end
        PFSW_H_RDHI: begin
          if (BUS.tbl_ack) begin
            state <= PFSW_H_IDLE;
          end
        end
        default: state <= PFSW_H_IDLE;
      endcase
    end
  end

  // Command capture, word index and idle-cycle count
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      prog <= 1'b0;
      addr <= 24'h000000;
      idx <= 5'h00;
      nop_cnt <= 2'h0;
    end else begin
      if (state == PFSW_H_IDLE) begin
        prog <= CMD_PROG_I;
        addr <= CMD_VALID_I ? CMD_ADDR_I : RD_ADDR_I;
        idx <= 5'h00;
      end else if (state == PFSW_H_LATHI && BUS.tbl_ack) begin
        idx <= idx + 5'h01; // R5
      end
      nop_cnt <= (state == PFSW_H_NOP) ? nop_cnt + 2'h1 : 2'h0;
    end
  end

  // Table handshake tracking and data holding
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      waiting <= 1'b0;
      hi_hold <= 8'h00;
      lo_hold <= 16'h0000;
      RD_DATA_O <= 24'h000000;
    end else begin
      waiting <= BUS.tbl_ack ? 1'b0 : (waiting | BUS.tbl_req);
      if (state == PFSW_H_LATLO && BUS.tbl_req) begin
        hi_hold <= WORD_DATA_I[23:16];
      end
      if (state == PFSW_H_RDLO && BUS.tbl_ack) begin
        lo_hold <= BUS.tbl_rdata;
      end
      if (state == PFSW_H_RDHI && BUS.tbl_ack) begin
        RD_DATA_O <= {BUS.tbl_rdata[7:0], lo_hold};
      end
    end
  end

  // Completion pulses
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      DONE_O <= 1'b0;
      RD_DONE_O <= 1'b0;
    end else begin
      DONE_O <= (state == PFSW_H_WAIT) && !BUS.stall;
      RD_DONE_O <= (state == PFSW_H_RDHI) && BUS.tbl_ack;
    end
  end
endmodule
`default_nettype wire

// [hw/pfsw_if.sv]
`default_nettype none
interface pfsw_if;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  logic tbl_req;
  logic tbl_we;
  logic tbl_high;
  logic tbl_byte;
  logic [7:0] tbl_page;
  logic [15:0] tbl_ofs;
  logic [15:0] tbl_wdata;
  logic [15:0] tbl_rdata;
  logic tbl_ack;
  logic stall;
  modport dev (
    input reg_wr, reg_rd, reg_addr, reg_wdata,
    input tbl_req, tbl_we, tbl_high, tbl_byte, tbl_page, tbl_ofs, tbl_wdata,
    output reg_rdata, reg_rvalid, tbl_rdata, tbl_ack, stall
  );
  modport host (
    output reg_wr, reg_rd, reg_addr, reg_wdata,
    output tbl_req, tbl_we, tbl_high, tbl_byte, tbl_page, tbl_ofs, tbl_wdata,
    input reg_rdata, reg_rvalid, tbl_rdata, tbl_ack, stall
  );
endinterface
`default_nettype wire

// [hw/pfsw_pkg.sv]
`default_nettype none
`include "pfsw_cfg.svh"
package pfsw_pkg;
  typedef logic [23:0] pfsw_word_t;
  typedef enum logic [2:0] {
    PFSW_D_IDLE = 3'h1,
    PFSW_D_ERASE = 3'h2,
    PFSW_D_PROG = 3'h4
  } pfsw_dev_state_t;
  typedef enum logic [2:0] {
    PFSW_K_NONE = 3'h1,
    PFSW_K_FIRST = 3'h2,
    PFSW_K_ARMED = 3'h4
  } pfsw_key_state_t;
  typedef enum logic [12:0] {
    PFSW_H_IDLE = 13'h0001,
    PFSW_H_CTRL = 13'h0002,
    PFSW_H_ADRU = 13'h0004,
    PFSW_H_ADRL = 13'h0008,
    PFSW_H_LATLO = 13'h0010,
    PFSW_H_LATHI = 13'h0020,
    PFSW_H_KEY1 = 13'h0040,
    PFSW_H_KEY2 = 13'h0080,
    PFSW_H_START = 13'h0100,
    PFSW_H_NOP = 13'h0200,
    PFSW_H_WAIT = 13'h0400,
    PFSW_H_RDLO = 13'h0800,
    PFSW_H_RDHI = 13'h1000
  } pfsw_host_state_t;
endpackage
`default_nettype wire

// [verif/pfsw_props.sv]
`default_nettype none
`include "pfsw_cfg.svh"
module pfsw_props #(
  parameter int unsigned OP_CYCLES = 20
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  input wire logic reg_wr,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic tbl_req,
  input wire logic tbl_we,
  input wire logic tbl_high,
  input wire logic [15:0] tbl_ofs,
  input wire logic tbl_ack,
  input wire logic stall
);
  // ****************************************
  // Decoded host actions
  // ****************************************
  logic k55, kaa, go, lo_wr;
  logic [15:0] busy_cnt;
  // Key writes, a valid start write and a low latch write
  assign k55 = reg_wr && reg_addr == `PFSW_ADDR_KEY && reg_wdata[7:0] == `PFSW_KEY_FIRST;
  assign kaa = reg_wr && reg_addr == `PFSW_ADDR_KEY && reg_wdata[7:0] == `PFSW_KEY_SECOND;
  assign go = reg_wr && reg_addr == `PFSW_ADDR_CTRL && reg_wdata[15:14] == 2'h3 && !stall
    && (reg_wdata[6:0] == `PFSW_OP_ERASE_ROW || reg_wdata[6:0] == `PFSW_OP_PROG_ROW);
  assign lo_wr = tbl_req && tbl_we && !tbl_high;
  // Counts the cycles of the running stall
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      busy_cnt <= 16'h0000;
    end else if (stall) begin
      busy_cnt <= busy_cnt + 16'h0001;
    end else begin
      busy_cnt <= 16'h0000;
    end
  end
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_B_I);
  sequence s_unlock;
    k55 ##1 kaa ##1 go;
  endsequence
  property p_start;
    s_unlock |=> stall;
  endproperty
  a_start: assert property (p_start)
    else $error("unlocked start did not stall");
  property p_lock;
    $rose(stall) |-> $past(go) && $past(kaa, 2) && $past(k55, 3);
  endproperty
  a_lock: assert property (p_lock)
    else $error("stall without unlock");
  property p_len;
    $fell(stall) |-> busy_cnt == 16'(OP_CYCLES);
  endproperty
  a_len: assert property (p_len)
    else $error("operation length wrong");
  property p_cap;
    stall |-> busy_cnt < 16'(OP_CYCLES) && !tbl_ack;
  endproperty
  a_cap: assert property (p_cap)
    else $error("stall too long or ack in stall");
  property p_ack;
    tbl_req && !stall && !tbl_ack |=> tbl_ack ##1 !tbl_ack;
  endproperty
  a_ack: assert property (p_ack)
    else $error("table ack timing wrong");
  property p_pair;
    tbl_req && tbl_we && tbl_high |-> $past(lo_wr, 2) && $past(tbl_ofs, 2) == tbl_ofs;
  endproperty
  a_pair: assert property (p_pair)
    else $error("high write not paired with low");
  property p_order;
    lo_wr && tbl_ofs[5:0] != 6'h00 |-> $past(lo_wr, 4) && $past(tbl_ofs, 4) + 16'h0002 == tbl_ofs;
  endproperty
  a_order: assert property (p_order)
    else $error("latch order wrong");
  property p_align;
    lo_wr && !$past(lo_wr, 4) |-> tbl_ofs[5:0] == 6'h00;
  endproperty
  a_align: assert property (p_align)
    else $error("latch load off row boundary");
  property p_nop;
    $rose(stall) |-> (!reg_wr && !tbl_req) [*2];
  endproperty
  a_nop: assert property (p_nop)
    else $error("no idle cycles after start");
endmodule
`default_nettype wire

// [verif/pfsw_tb_top.sv]
`default_nettype none
`include "pfsw_cfg.svh"
module pfsw_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Benches, instances and helpers
  // ****************************************
  localparam int unsigned OPC = 20;
  localparam logic [15:0] AC = `PFSW_ADDR_CTRL;
  localparam logic [15:0] AL = `PFSW_ADDR_LOW;
  localparam logic [15:0] AK = `PFSW_ADDR_KEY;
  logic clk, rst_b, cmd_valid, cmd_prog, cmd_ready, rd_valid, rd_done, done, busy_a, op_done_b;
  logic [23:0] cmd_addr, rd_addr, rd_data, word_data;
  logic [4:0] word_idx;
  int miscompares, total_checks;
  // Rows: program flag, row address, word index, expected word
  logic [53:0] rows [5] = '{
    {1'b0, 24'h000040, 5'h03, 24'hFFFFFF}, {1'b1, 24'h000040, 5'h00, 24'h000040},
    {1'b1, 24'h000080, 5'h1F, 24'h1F009F}, {1'b0, 24'h000080, 5'h1F, 24'hFFFFFF},
    {1'b1, 24'h001FC0, 5'h11, 24'h111FD1}};
  pfsw_if bus_a();
  pfsw_if bus_b();
  // Latch word: index in the top byte, row base plus index below
  assign word_data = {3'h0, word_idx, cmd_addr[15:0] + {11'h000, word_idx}};
  pfsw_dev #(.OP_CYCLES(OPC)) pfsw_dev_i (.CLK_SYS_I(clk), .RST_B_I(rst_b), .BUS(bus_a),
    .BUSY_O(busy_a), .OP_DONE_O());
  pfsw_host pfsw_host_i (.CLK_SYS_I(clk), .RST_B_I(rst_b), .BUS(bus_a),
    .CMD_VALID_I(cmd_valid), .CMD_PROG_I(cmd_prog), .CMD_ADDR_I(cmd_addr),
    .CMD_READY_O(cmd_ready), .WORD_IDX_O(word_idx), .WORD_DATA_I(word_data),
    .RD_VALID_I(rd_valid), .RD_ADDR_I(rd_addr), .RD_DATA_O(rd_data),
    .RD_DONE_O(rd_done), .DONE_O(done));
  pfsw_dev #(.OP_CYCLES(OPC)) pfsw_dev_b_i (.CLK_SYS_I(clk), .RST_B_I(rst_b), .BUS(bus_b),
    .BUSY_O(), .OP_DONE_O(op_done_b));
  pfsw_props #(.OP_CYCLES(OPC)) pfsw_props_i (.CLK_SYS_I(clk), .RST_B_I(rst_b),
    .reg_wr(bus_a.reg_wr), .reg_addr(bus_a.reg_addr), .reg_wdata(bus_a.reg_wdata),
    .tbl_req(bus_a.tbl_req), .tbl_we(bus_a.tbl_we), .tbl_high(bus_a.tbl_high),
    .tbl_ofs(bus_a.tbl_ofs), .tbl_ack(bus_a.tbl_ack), .stall(bus_a.stall));
  // Clock at 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Compares one value and counts it
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, exp);
    end
  endtask
  // Prints the counts and the verdict
  task automatic end_sim();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Hands a command or a read to the host, waits for its done pulse
  task automatic host_op(input logic rd, input logic prog, input logic [23:0] a, output int nb);
    int n;
    n = 0;
    nb = 0;
    @(posedge clk);
    cmd_valid <= !rd;
    rd_valid <= rd;
    cmd_prog <= prog;
    cmd_addr <= a;
    rd_addr <= a;
    @(posedge clk);
    cmd_valid <= 1'b0;
    rd_valid <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      n++;
      nb += int'(busy_a === 1'b1);
    end while ((rd ? rd_done : done) !== 1'b1 && n < 3000);
    check({23'h0, (rd ? rd_done : done)}, 24'h000001);
  endtask
  // Register write on the second bench, held for one edge
  task automatic wr_b(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_b.reg_wr <= 1'b1;
    bus_b.reg_addr <= a;
    bus_b.reg_wdata <= d;
  endtask
  task automatic idle_b();
    @(posedge clk);
    bus_b.reg_wr <= 1'b0;
    bus_b.reg_rd <= 1'b0;
    bus_b.tbl_req <= 1'b0;
  endtask
  task automatic rd_b(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    bus_b.reg_rd <= 1'b1;
    bus_b.reg_addr <= a;
    idle_b();
    #1;
    check({23'h0, bus_b.reg_rvalid}, 24'h000001);
    check({8'h00, bus_b.reg_rdata}, {8'h00, exp});
  endtask
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end
  // Main sequence
  initial begin
    int nb;
    {cmd_valid, cmd_prog, rd_valid, cmd_addr, rd_addr} = '0;
    {bus_b.reg_wr, bus_b.reg_rd, bus_b.reg_addr, bus_b.reg_wdata} = '0;
    {bus_b.tbl_req, bus_b.tbl_we, bus_b.tbl_high, bus_b.tbl_byte} = '0;
    {bus_b.tbl_page, bus_b.tbl_ofs, bus_b.tbl_wdata} = '0;
    rst_b = 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    check({22'h0, cmd_ready, busy_a}, 24'h000002);
    for (int i = 0; i < 5; i++) begin
      host_op(1'b0, rows[i][53], rows[i][52:29], nb);
      check(24'(nb), 24'(OPC));
      host_op(1'b1, 1'b0, rows[i][52:29] + {18'h00000, rows[i][28:24], 1'b0}, nb);
      check(rd_data, rows[i][23:0]);
      $display("row test %0d done", i);
    end
    wr_b(AK, 16'h0055);
    wr_b(AK, 16'h0055);
    wr_b(AC, `PFSW_CTRL_START | `PFSW_CTRL_ERASE);
    idle_b();
    #1;
    check({23'h0, bus_b.stall}, 24'h000000);
    wr_b(AK, 16'h0055);
    wr_b(AL, 16'h0040);
    wr_b(AK, 16'h00AA);
    wr_b(AC, `PFSW_CTRL_START | `PFSW_CTRL_ERASE);
    idle_b();
    #1;
    check({23'h0, bus_b.stall}, 24'h000000);
    $display("key refusal test done");
    wr_b(AK, 16'h0055);
    wr_b(AK, 16'h00AA);
    wr_b(AC, `PFSW_CTRL_START | `PFSW_CTRL_ERASE);
    idle_b();
    #1;
    check({23'h0, bus_b.stall}, 24'h000001);
    rd_b(AC, 16'hC041);
    repeat (OPC - 2) @(posedge clk);
    #1;
    check({23'h0, op_done_b}, 24'h000001);
    rd_b(AC, `PFSW_CTRL_ERASE);
    rd_b(AK, 16'h0000);
    wr_b(AK, 16'h0055);
    wr_b(AK, 16'h00AA);
    wr_b(AC, 16'hC07F);
    idle_b();
    rd_b(AC, 16'h607F);
    $display("unlock test done");
    @(posedge clk);
    bus_b.tbl_req <= 1'b1;
    bus_b.tbl_we <= 1'b1;
    bus_b.tbl_page <= 8'h01;
    bus_b.tbl_ofs <= 16'h1234;
    bus_b.tbl_wdata <= 16'hBEEF;
    idle_b();
    #1;
    check({23'h0, bus_b.tbl_ack}, 24'h000001);
    rd_b(AL, 16'h1234);
    rd_b(`PFSW_ADDR_UPPER, 16'h0001);
    wr_b(AL, 16'h0ABC);
    idle_b();
    rd_b(AL, 16'h0ABC);
    $display("address test done");
    wr_b(AK, 16'h0055);
    wr_b(AK, 16'h00AA);
    wr_b(AC, `PFSW_CTRL_START | `PFSW_CTRL_PROG);
    idle_b();
    repeat (5) @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    #1;
    check({23'h0, bus_b.stall}, 24'h000000);
    rd_b(AC, `PFSW_CTRL_RESET);
    $display("reset test done");
    end_sim();
  end
endmodule
`default_nettype wire
